// ---- mih_handshake.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1: Trouble flag clears about 1.5 s after power-up when no alarm present.
// RULE2: Ready flag on after power-up; off on trouble or held reset request; code drops it on alarm only, not in the power-up trouble window.
// RULE3: Monitor request loads first monitor word and raises monitor done together.
// RULE4: One station: second monitor value returned in second output word.
// RULE5: Two stations: second monitor value returned in sixth output word; code returns it in the fifth word.
// RULE6: Two stations, 32-bit first monitor: low and upper halves in words one, two.
// RULE7: Two stations, 32-bit second monitor: low in sixth, upper in seventh word; code puts low in fifth, upper in sixth word.
// RULE8: Instruction request executes code, then instruction done flag rises.
// RULE9: Write data stored on instruction request, done raised after write completes.
// RULE10: Response word is 0000 when all input codes executed without error.
// RULE11: Unsupported code or bad data puts an error code in response word; code flags unsupported codes only and never checks write data.
// RULE12: Read instruction result placed in read word on completion.
// RULE13: Unsupported monitor code zeroes all monitor data words.
// RULE14: Unsupported read code zeroes the read result word.
// RULE15: Upper monitor word is sign extension when value has no upper part.
// RULE16: Done flags drop after request removed; master holds request until done.
module mih_handshake #(
    parameter int TROUBLE_CYC = mih_pkg::TROUBLE_CLEAR_CYC,
    parameter int AW = mih_pkg::TABLE_ADDR_W
) (
    clk_sys,
    sys_rst,
    two_stations,
    alarm_active,
    in_words,
    monitor_request_flag,
    instruction_request_flag,
    reset_request_single,
    reset_request_dual,
    mon_sel_one,
    mon_sel_two,
    mon_one,
    mon_two,
    out_words,
    monitor_done_flag,
    instruction_done_flag,
    trouble_flag,
    comm_ready_flag
);
    input wire logic clk_sys;
    input wire logic sys_rst;
    input wire logic two_stations;
    input wire logic alarm_active;
    input wire mih_pkg::mih_in_words_t in_words;
    input wire logic monitor_request_flag;
    input wire logic instruction_request_flag;
    input wire logic reset_request_single;
    input wire logic reset_request_dual;
    output logic [15:0] mon_sel_one;
    output logic [15:0] mon_sel_two;
    input wire mih_pkg::mih_mon_t mon_one;
    input wire mih_pkg::mih_mon_t mon_two;
    output mih_pkg::mih_out_words_t out_words;
    output logic monitor_done_flag;
    output logic instruction_done_flag;
    output logic trouble_flag;
    output logic comm_ready_flag;

    // ----------------------------------------
    // Power-up trouble window
    // ----------------------------------------
    logic [31:0] pwr_cnt_reg;
    logic pwr_done_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwr_cnt_reg <= 32'h0000_0000;
            pwr_done_reg <= 1'b0;
        end else if (!pwr_done_reg) begin
            pwr_cnt_reg <= pwr_cnt_reg + 32'h0000_0001;
            if (pwr_cnt_reg >= 32'(TROUBLE_CYC - 1)) begin
                pwr_done_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            trouble_flag <= 1'b1;
        end else begin
            trouble_flag <= !pwr_done_reg || alarm_active; // [RULE1]
        end
    end

    logic rst_req;
    assign rst_req = two_stations ? reset_request_dual : reset_request_single;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            comm_ready_flag <= 1'b0;
        end else begin
            comm_ready_flag <= !alarm_active && !rst_req; // [RULE2]
        end
    end

    // ----------------------------------------
    // Monitor exchange
    // ----------------------------------------
    logic mon_err_reg;
    logic instr_err_reg;
    logic mon_take;
    logic mon_bad;
    logic [15:0] mon_word_one_reg;
    logic [15:0] mon_word_two_reg;
    logic [15:0] mon_low_out_reg;
    logic [15:0] mon_high_out_reg;
    logic [15:0] mon_word_one_next;
    logic [15:0] mon_word_two_next;
    logic [15:0] mon_low_out_next;
    logic [15:0] mon_high_out_next;
    logic [15:0] resp_reg;
    logic [15:0] resp_next;
    logic [15:0] read_reg;

    assign mon_sel_one = in_words.monitor_code_one;
    assign mon_sel_two = in_words.monitor_code_two;
    assign mon_take = monitor_request_flag && !monitor_done_flag;
    assign mon_bad = !mon_one.ok || !mon_two.ok;

    function automatic logic [15:0] upper_word(input mih_pkg::mih_mon_t m);
        if (m.wide) begin
            upper_word = m.value[31:16];
        end else begin
            upper_word = {16{m.value[15]}}; // [RULE15]
        end
    endfunction

    always_comb begin
        mon_word_one_next = mon_one.value[15:0]; // [RULE3]
        mon_word_two_next = mon_two.value[15:0]; // [RULE4]
        mon_low_out_next = mih_pkg::WORD_RST;
        mon_high_out_next = mih_pkg::WORD_RST;
        if (mon_bad) begin
            mon_word_one_next = mih_pkg::WORD_RST; // [RULE13]
            mon_word_two_next = mih_pkg::WORD_RST;
        end else if (two_stations) begin
            mon_word_two_next = upper_word(mon_one); // [RULE6]
            mon_low_out_next = mon_two.value[15:0]; // [RULE5] [RULE7]
            mon_high_out_next = upper_word(mon_two); // [RULE7]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            monitor_done_flag <= 1'b0;
        end else if (mon_take) begin
            monitor_done_flag <= 1'b1; // [RULE3]
        end else if (!monitor_request_flag) begin
            monitor_done_flag <= 1'b0; // [RULE16]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mon_word_one_reg <= mih_pkg::WORD_RST;
            mon_word_two_reg <= mih_pkg::WORD_RST;
            mon_low_out_reg <= mih_pkg::WORD_RST;
            mon_high_out_reg <= mih_pkg::WORD_RST;
        end else if (mon_take) begin
            mon_word_one_reg <= mon_word_one_next; // [RULE3]
            mon_word_two_reg <= mon_word_two_next;
            mon_low_out_reg <= mon_low_out_next; // [RULE5]
            mon_high_out_reg <= mon_high_out_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mon_err_reg <= 1'b0;
        end else if (mon_take) begin
            mon_err_reg <= mon_bad; // [RULE11]
        end
    end

    // ----------------------------------------
    // Instruction state machine
    // ----------------------------------------
    typedef enum logic [3:0] {
        MIH_IDLE = 4'b0001,
        MIH_EXEC = 4'b0010,
        MIH_FETCH = 4'b0100,
        MIH_DONE = 4'b1000
    } mih_state_t;

    mih_state_t state_reg;
    logic mem_we;
    logic [15:0] mem_rdata;
    logic is_read;
    logic is_write;
    logic code_ok;

    assign is_read = in_words.instruction_word <= mih_pkg::READ_CODE_MAX;
    assign is_write = !is_read && (in_words.instruction_word[15:AW] == {(16 - AW){1'b0}}
        || in_words.instruction_word[15:8] == 8'h12);
    assign code_ok = is_read || is_write;
    assign mem_we = (state_reg == MIH_EXEC) && is_write && code_ok; // [RULE9]

    mih_param_mem #(
        .AW(AW)
    ) u_mem (
        .clk_sys(clk_sys),
        .we(mem_we),
        .addr(in_words.instruction_word[AW-1:0]),
        .wdata(in_words.write_payload),
        .rdata(mem_rdata)
    );

    mih_state_t state_next;
    logic instr_release;

    assign instr_release = !instruction_request_flag && instruction_done_flag;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MIH_IDLE: begin
                if (instruction_request_flag) begin
                    state_next = MIH_EXEC; // [RULE8]
                end
            end
            MIH_EXEC: begin
                if (code_ok) begin
                    state_next = MIH_FETCH;
                end else begin
                    state_next = MIH_DONE;
                end
            end
            MIH_FETCH: begin
                state_next = MIH_DONE;
            end
            MIH_DONE: begin
                if (instr_release) begin
                    state_next = MIH_IDLE; // [RULE16]
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= MIH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            instruction_done_flag <= 1'b0;
        end else if (state_reg == MIH_DONE && instr_release) begin
            instruction_done_flag <= 1'b0; // [RULE16]
        end else if (state_reg == MIH_DONE) begin
            instruction_done_flag <= 1'b1; // [RULE8] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            instr_err_reg <= 1'b0;
        end else if (state_reg == MIH_EXEC) begin
            instr_err_reg <= !code_ok; // [RULE11]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            read_reg <= mih_pkg::WORD_RST;
        end else if (state_reg == MIH_EXEC && !code_ok) begin
            read_reg <= mih_pkg::WORD_RST; // [RULE14]
        end else if (state_reg == MIH_FETCH && is_read) begin
            read_reg <= mem_rdata; // [RULE12]
        end
    end

    // ----------------------------------------
    // Response word
    // ----------------------------------------
    always_comb begin
        resp_next = mih_pkg::RESP_OK; // [RULE10]
        if (mon_err_reg) begin
            resp_next = mih_pkg::RESP_BAD_MON; // [RULE11]
        end else if (instr_err_reg) begin
            resp_next = mih_pkg::RESP_BAD_INSTR; // [RULE11]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            resp_reg <= mih_pkg::RESP_OK;
        end else begin
            resp_reg <= resp_next;
        end
    end

    // ----------------------------------------
    // Output word carrier
    // ----------------------------------------
    assign out_words = {mon_word_one_reg, mon_word_two_reg, resp_reg, read_reg,
        mon_low_out_reg, mon_high_out_reg};
endmodule

// ---- mih_handshake_checker.sv ----
`timescale 1ns/1ps
module mih_handshake_checker #(
    parameter int TROUBLE_CYC = mih_pkg::TROUBLE_CLEAR_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic two_stations,
    input wire logic alarm_active,
    input wire logic monitor_request_flag,
    input wire logic instruction_request_flag,
    input wire logic reset_request_single,
    input wire logic reset_request_dual,
    input wire mih_pkg::mih_mon_t mon_one,
    input wire mih_pkg::mih_mon_t mon_two,
    input wire mih_pkg::mih_out_words_t out_words,
    input wire logic monitor_done_flag,
    input wire logic instruction_done_flag,
    input wire logic trouble_flag,
    input wire logic comm_ready_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    int unsigned up_cnt;
    logic alarm_seen;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) up_cnt <= 0;
        else if (up_cnt < TROUBLE_CYC + 4) up_cnt <= up_cnt + 1;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) alarm_seen <= 1'b0;
        else if (alarm_active) alarm_seen <= 1'b1;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    mon_rise_a: assert property ($rose(monitor_done_flag) |-> $past(monitor_request_flag))
        else $error("monitor done without request");
    mon_hold_a: assert property (monitor_done_flag && monitor_request_flag |=> monitor_done_flag)
        else $error("monitor done dropped early");
    mon_drop_a: assert property (monitor_done_flag && !monitor_request_flag |=> !monitor_done_flag)
        else $error("monitor done stuck");
    ins_rise_a: assert property ($rose(instruction_done_flag) |-> $past(instruction_request_flag))
        else $error("instruction done without request");
    ins_drop_a: assert property (instruction_done_flag && !instruction_request_flag
        |=> !instruction_done_flag) else $error("instruction done stuck");
    ready_rst_a: assert property ((two_stations ? reset_request_dual : reset_request_single)
        |=> !comm_ready_flag) else $error("ready during reset request");
    ready_alarm_a: assert property (alarm_active |=> !comm_ready_flag)
        else $error("ready during alarm");
    trouble_clr_a: assert property (!alarm_seen && up_cnt == TROUBLE_CYC + 4 |-> !trouble_flag)
        else $error("trouble not cleared");
    mon_zero_a: assert property ($rose(monitor_done_flag) && !($past(mon_one.ok) && $past(mon_two.ok))
        |-> out_words.monitor_value_one == 16'h0000 && out_words.monitor_two_low_out == 16'h0000)
        else $error("bad monitor data not zero");
    one_stn_a: assert property ($rose(monitor_done_flag) && !$past(two_stations)
        |-> out_words.monitor_two_low_out == 16'h0000 && out_words.monitor_two_high_out == 16'h0000)
        else $error("one station high words used");
    cover property ($rose(monitor_done_flag) && two_stations);
    cover property ($rose(instruction_done_flag));
    cover property ($fell(trouble_flag));
endmodule
bind mih_handshake mih_handshake_checker #(.TROUBLE_CYC(TROUBLE_CYC)) chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .two_stations(two_stations), .alarm_active(alarm_active),
    .monitor_request_flag(monitor_request_flag), .instruction_request_flag(instruction_request_flag),
    .reset_request_single(reset_request_single), .reset_request_dual(reset_request_dual),
    .mon_one(mon_one), .mon_two(mon_two), .out_words(out_words),
    .monitor_done_flag(monitor_done_flag), .instruction_done_flag(instruction_done_flag),
    .trouble_flag(trouble_flag), .comm_ready_flag(comm_ready_flag));

// ---- mih_param_mem.sv ----
`timescale 1ns/1ps
module mih_param_mem #(
    parameter int AW = 8
) (
    clk_sys,
    we,
    addr,
    wdata,
    rdata
);
    input wire logic clk_sys;
    input wire logic we;
    input wire logic [AW-1:0] addr;
    input wire logic [15:0] wdata;
    output logic [15:0] rdata;

    logic [15:0] mem [0:(1<<AW)-1];

    // ----------------------------------------
    // Registered read
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ---- mih_pkg.sv ----
package mih_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int TROUBLE_CLEAR_MS = 1500;
    localparam int TROUBLE_CLEAR_CYC = TROUBLE_CLEAR_MS * 1000 * CLK_MHZ;

    // ----------------------------------------
    // Response codes and reset values
    // ----------------------------------------
    localparam logic [15:0] RESP_OK = 16'h0000;
    localparam logic [15:0] RESP_BAD_MON = 16'h0001;
    localparam logic [15:0] RESP_BAD_INSTR = 16'h0002;
    localparam logic [15:0] RESP_BAD_DATA = 16'h0003;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ----------------------------------------
    // Instruction code split
    // ----------------------------------------
    localparam logic [15:0] READ_CODE_MAX = 16'h0aff;
    localparam int TABLE_ADDR_W = 8;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] monitor_code_one;
        logic [15:0] monitor_code_two;
        logic [15:0] instruction_word;
        logic [15:0] write_payload;
    } mih_in_words_t;

    typedef struct packed {
        logic [15:0] monitor_value_one;
        logic [15:0] monitor_value_two;
        logic [15:0] response_status;
        logic [15:0] read_result;
        logic [15:0] monitor_two_low_out;
        logic [15:0] monitor_two_high_out;
    } mih_out_words_t;

    typedef struct packed {
        logic ok;
        logic wide;
        logic [31:0] value;
    } mih_mon_t;

endpackage

// ---- mih_value_src.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Monitor value source
// ----------------------------------------
module mih_value_src (
    input wire logic [15:0] code,
    output mih_pkg::mih_mon_t mon
);
    // Known codes below 0100h; odd codes carry a full 32-bit value
    assign mon.ok = (code[15:8] == 8'h00);
    assign mon.wide = code[0];
    assign mon.value = {~code, code ^ 16'h8c31};
endmodule

// ---- monitor_instruction_handshake_tb.sv ----
`timescale 1ns/1ps
module monitor_instruction_handshake_tb;
    localparam int TCYC = 20;
    logic clk_sys = 1'b0, sys_rst = 1'b1, two_stations = 1'b0, alarm_active = 1'b0;
    logic mreq = 1'b0, ireq = 1'b0, rst_one = 1'b0, rst_two = 1'b0;
    logic mdone, idone, trouble_flag, comm_ready_flag;
    logic [15:0] sel1, sel2;
    mih_pkg::mih_in_words_t in_words = '0;
    mih_pkg::mih_out_words_t ow;
    mih_pkg::mih_mon_t mon1, mon2;
    int mismatches = 0, check_count = 0, cycles = 0;
    int mem [int];
    logic [7:0] a;
    logic [15:0] d;
    always #2 clk_sys = ~clk_sys;
    mih_handshake #(.TROUBLE_CYC(TCYC)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .two_stations(two_stations), .alarm_active(alarm_active), .in_words(in_words),
        .monitor_request_flag(mreq), .instruction_request_flag(ireq),
        .reset_request_single(rst_one), .reset_request_dual(rst_two), .mon_sel_one(sel1),
        .mon_sel_two(sel2), .mon_one(mon1), .mon_two(mon2), .out_words(ow),
        .monitor_done_flag(mdone), .instruction_done_flag(idone),
        .trouble_flag(trouble_flag), .comm_ready_flag(comm_ready_flag));
    mih_value_src src1 (.code(sel1), .mon(mon1));
    mih_value_src src2 (.code(sel2), .mon(mon2));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_done(input bit ins, input logic lvl);
        int i;
        i = 0;
        do begin
            @(negedge clk_sys);
            i++;
        end while (((ins ? idone : mdone) !== lvl) && i < 50);
        chk(16'(i < 50), 16'h0001, "handshake wait");
    endtask
    task automatic mon_run(input logic two, input logic [15:0] c1, input logic [15:0] c2);
        logic [15:0] l1, l2, s1, s2;
        logic bad;
        bad = (c1[15:8] != 8'h00) || (c2[15:8] != 8'h00);
        l1 = bad ? 16'h0000 : c1 ^ 16'h8c31;
        l2 = bad ? 16'h0000 : c2 ^ 16'h8c31;
        s1 = bad ? 16'h0000 : (c1[0] ? ~c1 : {16{l1[15]}});
        s2 = bad ? 16'h0000 : (c2[0] ? ~c2 : {16{l2[15]}});
        @(posedge clk_sys);
        two_stations <= two;
        in_words.monitor_code_one <= c1;
        in_words.monitor_code_two <= c2;
        @(posedge clk_sys);
        mreq <= 1'b1;
        wait_done(1'b0, 1'b1);
        repeat (3) @(negedge clk_sys);
        chk(ow.monitor_value_one, l1, "monitor word one");
        chk(ow.monitor_value_two, two ? s1 : l2, "monitor word two");
        chk(ow.monitor_two_low_out, two ? l2 : 16'h0000, "monitor two low");
        chk(ow.monitor_two_high_out, two ? s2 : 16'h0000, "monitor two high");
        chk(ow.response_status, bad ? mih_pkg::RESP_BAD_MON : mih_pkg::RESP_OK, "mon resp");
        @(posedge clk_sys);
        mreq <= 1'b0;
        wait_done(1'b0, 1'b0);
    endtask
    task automatic ins_run(input logic [15:0] code, input logic [15:0] data);
        logic wr, rd;
        wr = (code[15:8] == 8'h12);
        rd = (code <= mih_pkg::READ_CODE_MAX);
        @(posedge clk_sys);
        in_words.instruction_word <= code;
        in_words.write_payload <= data;
        ireq <= 1'b1;
        wait_done(1'b1, 1'b1);
        repeat (3) @(negedge clk_sys);
        if (wr) mem[code[7:0]] = data;
        if (rd) chk(ow.read_result, 16'(mem[code[7:0]]), "read data");
        if (!rd && !wr) chk(ow.read_result, 16'h0000, "bad read zero");
        chk(ow.response_status, (rd || wr) ? mih_pkg::RESP_OK : mih_pkg::RESP_BAD_INSTR, "ins resp");
        @(posedge clk_sys);
        ireq <= 1'b0;
        wait_done(1'b1, 1'b0);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("ERROR %0t timeout", $time);
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'he4b25fa6));
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(comm_ready_flag, 1'b1, "ready at power on");
        repeat (TCYC + 4) @(negedge clk_sys);
        chk(trouble_flag, 1'b0, "trouble cleared");
        $display("test power_on done");
        for (int i = 0; i < 8; i++) mon_run(i[0], 16'($urandom & 32'h1f), 16'($urandom & 32'h1f));
        mon_run(1'b1, 16'h0100, 16'h0003);
        mon_run(1'b0, 16'h0002, 16'h0ff0);
        mon_run(1'b1, 16'h000a, 16'h000e);
        mon_run(1'b1, 16'h0007, 16'h0011);
        $display("test monitor done");
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            d = 16'($urandom);
            ins_run({8'h12, a}, d);
            ins_run({4'h0, 4'($urandom_range(10)), a}, 16'h0000);
        end
        ins_run(16'h0b00, 16'h1234);
        ins_run(16'hffff, 16'h0000);
        $display("test instruction done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            two_stations <= i[0];
            rst_one <= !i[0];
            rst_two <= i[0];
            repeat (2) @(negedge clk_sys);
            chk(comm_ready_flag, 1'b0, "ready in reset request");
            @(posedge clk_sys);
            rst_one <= 1'b0;
            rst_two <= 1'b0;
            repeat (2) @(negedge clk_sys);
            chk(comm_ready_flag, 1'b1, "ready after reset request");
        end
        @(posedge clk_sys);
        alarm_active <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(comm_ready_flag, 1'b0, "ready in trouble");
        chk(trouble_flag, 1'b1, "trouble on alarm");
        $display("test status done");
        wrap_up();
    end
endmodule
